// *** include/timer_pkg.sv ***
// Purpose: Shared constants and carriers of the four counter/timer unit
// Assumes: 8-bit register port, one 100 MHz system clock
// Notes: Register offsets are byte addresses on the plain register port
//
// Behaviour
// - Four independent 16-bit counter/timers
// - Timers 0/1: 13-bit, 16-bit, 8-bit reload
// - Split 8-bit mode on timer 0 only
// - Timers 2/3: 16-bit or dual 8-bit reload
// - Timers 0/1 tick from prescaler or sysclk
// - Timers 2/3: sysclk, sysclk/12, ext/8
// - Counter mode counts falling input edges
// - Counts events up to sysclk/4
// - Prescale 00=/12 01=/4 10=/48 11=ext/8
// - Sysclk select set means sysclk, ignored counting
// - 13-bit wrap 1fff to 0 sets flag
// - Timers 0/1 run needs run bit and open gate; timer 0's split high byte needs only timer 1's run bit
package timer_pkg;

  // ***********************************************
  // Register offsets
  // ***********************************************
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CLOCK = 8'h01;
  localparam logic [7:0] OFS_RUN = 8'h02;
  localparam logic [7:0] OFS_STATUS = 8'h03;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_RELOAD = 8'h10;

  // ***********************************************
  // Reset values and field positions
  // ***********************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int POS_RUN_T0 = 0;
  localparam int POS_RUN_T1 = 1;
  localparam int POS_RUN_T2 = 2;
  localparam int POS_RUN_T3 = 3;
  localparam int POS_SPLIT_T2 = 4;
  localparam int POS_SPLIT_T3 = 5;
  localparam int POS_ST_T0 = 0;
  localparam int POS_ST_T1 = 1;
  localparam int POS_ST_T2L = 2;
  localparam int POS_ST_T2H = 3;
  localparam int POS_ST_T3L = 4;
  localparam int POS_ST_T3H = 5;
  localparam int NUM_EVENTS = 6;

  // ***********************************************
  // Divider counts
  // ***********************************************
  localparam logic [5:0] DIV4_LAST = 6'h03;
  localparam logic [5:0] DIV12_LAST = 6'h0b;
  localparam logic [5:0] DIV48_LAST = 6'h2f;
  localparam logic [2:0] EXT8_LAST = 3'h7;

  // ***********************************************
  // Modes and carriers
  // ***********************************************
  typedef enum logic [1:0] {
    MODE_13BIT = 2'h0,
    MODE_16BIT = 2'h1,
    MODE_8RELOAD = 2'h2,
    MODE_SPLIT = 2'h3
  } classic_mode_e;

  typedef enum logic [1:0] {
    PRE_DIV12 = 2'h0,
    PRE_DIV4 = 2'h1,
    PRE_DIV48 = 2'h2,
    PRE_EXT8 = 2'h3
  } prescale_e;

  // One classic timer's mode nibble
  typedef struct packed {
    logic gate;
    logic counter;
    classic_mode_e mode;
  } classic_cfg_s;

  // Clock control byte
  typedef struct packed {
    logic t3_ext;
    logic t3_sys;
    logic t2_ext;
    logic t2_sys;
    logic timer1_sysclk_select;
    logic timer0_sysclk_select;
    prescale_e prescale_select;
  } clock_cfg_s;

endpackage : timer_pkg

// *** src/classic_timer.sv ***
// Purpose: One classic counter/timer with four modes
// Assumes: Ticks are one-cycle enables from the parent
// Notes: Writes from software win over a tick in the same cycle
module classic_timer #(
  parameter bit SPLIT_OK = 1'b1
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic tick_lo,
  input wire logic tick_hi,
  input wire timer_pkg::classic_mode_e mode,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [7:0] wdata,
  output logic [15:0] count,
  output logic ovf_lo,
  output logic ovf_hi
);
  logic [7:0] lo_r;
  logic [7:0] hi_r;
  wire [7:0] lo_inc = lo_r + 8'h01;
  wire [7:0] hi_inc = hi_r + 8'h01;
  wire lo5_wrap = lo_r[4:0] == 5'h1f;
  wire lo_wrap = lo_r == 8'hff;
  wire hi_wrap = hi_r == 8'hff;
  wire is13 = mode == timer_pkg::MODE_13BIT;
  wire is16 = mode == timer_pkg::MODE_16BIT;
  wire is8 = mode == timer_pkg::MODE_8RELOAD;
  wire split = (mode == timer_pkg::MODE_SPLIT) && SPLIT_OK;
  // A timer without split support holds in that mode
  wire halt = (mode == timer_pkg::MODE_SPLIT) && !SPLIT_OK;

  // Step and carry per mode
  wire [7:0] lo_step = is13 ? {lo_r[7:5], lo_inc[4:0]} : (is8 && lo_wrap) ? hi_r : lo_inc;
  wire carry = is13 ? lo5_wrap : is16 ? lo_wrap : 1'b0;
  wire run_lo = tick_lo && !halt;
  wire hi_go = (run_lo && carry) || (split && tick_hi);
  assign ovf_lo = run_lo && ((is8 || split) ? lo_wrap : (carry && hi_wrap));
  assign ovf_hi = split && tick_hi && hi_wrap;
  assign count = {hi_r, lo_r};

  // Count bytes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lo_r <= timer_pkg::RST_BYTE;
      hi_r <= timer_pkg::RST_BYTE;
    end else begin
      if (wr_lo) lo_r <= wdata;
      else if (run_lo) lo_r <= lo_step;
      if (wr_hi) hi_r <= wdata;
      else if (hi_go) hi_r <= hi_inc;
    end
  end
endmodule : classic_timer

// *** src/reload_timer.sv ***
// Purpose: One auto-reload timer, 16-bit or split into two bytes
// Assumes: Ticks are one-cycle enables from the parent
// Notes: Both halves share one tick; software writes win over ticks
module reload_timer (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic tick,
  input wire logic split,
  input wire logic wr_cnt_lo,
  input wire logic wr_cnt_hi,
  input wire logic wr_rl_lo,
  input wire logic wr_rl_hi,
  input wire logic [7:0] wdata,
  output logic [15:0] count,
  output logic [15:0] reload,
  output logic ovf_lo,
  output logic ovf_hi
);
  logic [15:0] cnt_r;
  logic [15:0] rl_r;
  wire [15:0] cnt_inc = cnt_r + 16'h0001;
  wire full = cnt_r == 16'hffff;
  wire lo_wrap = cnt_r[7:0] == 8'hff;
  wire hi_wrap = cnt_r[15:8] == 8'hff;
  wire [7:0] lo_add = cnt_r[7:0] + 8'h01;
  wire [7:0] hi_add = cnt_r[15:8] + 8'h01;

  // Next bytes: each half reloads from its own byte when split
  wire [7:0] lo_nxt = split ? (lo_wrap ? rl_r[7:0] : lo_add) : (full ? rl_r[7:0] : cnt_inc[7:0]);
  wire [7:0] hi_nxt = split ? (hi_wrap ? rl_r[15:8] : hi_add) : (full ? rl_r[15:8] : cnt_inc[15:8]);
  assign ovf_lo = tick && split && lo_wrap;
  assign ovf_hi = tick && (split ? hi_wrap : full);
  assign count = cnt_r;
  assign reload = rl_r;

  // Count and reload bytes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= {timer_pkg::RST_BYTE, timer_pkg::RST_BYTE};
      rl_r <= {timer_pkg::RST_BYTE, timer_pkg::RST_BYTE};
    end else begin
      if (wr_cnt_lo) cnt_r[7:0] <= wdata;
      else if (tick) cnt_r[7:0] <= lo_nxt;
      if (wr_cnt_hi) cnt_r[15:8] <= wdata;
      else if (tick) cnt_r[15:8] <= hi_nxt;
      if (wr_rl_lo) rl_r[7:0] <= wdata;
      if (wr_rl_hi) rl_r[15:8] <= wdata;
    end
  end
endmodule : reload_timer

// *** src/four_counter_timer_unit.sv ***
// Purpose: Four counter/timers with register port and one interrupt
// Assumes: Pins synchronous to mclk; gate inputs already at active-high level
// Notes: Count inputs still pass a two-stage synchroniser before edge detect
module four_counter_timer_unit (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [7:0] rdata,
  input wire logic count_input_zero,
  input wire logic count_input_one,
  input wire logic external_gate_input_zero,
  input wire logic external_gate_input_one,
  input wire logic ext_osc_clk,
  output logic irq
);

  // ***********************************************
  // Control registers
  // ***********************************************
  timer_pkg::classic_cfg_s cfg0_r;
  timer_pkg::classic_cfg_s cfg1_r;
  timer_pkg::clock_cfg_s clk_r;
  logic [7:0] run_r;
  logic [timer_pkg::NUM_EVENTS-1:0] status_r;
  logic [timer_pkg::NUM_EVENTS-1:0] mask_r;
  logic [timer_pkg::NUM_EVENTS-1:0] status_nxt;
  logic [timer_pkg::NUM_EVENTS-1:0] events;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // Address decode
  wire wr_mode = wr_strobe && addr == timer_pkg::OFS_MODE;
  wire wr_clock = wr_strobe && addr == timer_pkg::OFS_CLOCK;
  wire wr_run = wr_strobe && addr == timer_pkg::OFS_RUN;
  wire wr_status = wr_strobe && addr == timer_pkg::OFS_STATUS;
  wire wr_mask = wr_strobe && addr == timer_pkg::OFS_MASK;
  wire in_count = addr[7:3] == timer_pkg::OFS_COUNT[7:3];
  wire in_reload = addr[7:2] == timer_pkg::OFS_RELOAD[7:2];
  wire [7:0] wr_cnt_byte = (wr_strobe && in_count) ? (8'h01 << addr[2:0]) : 8'h00;
  wire [3:0] wr_rl_byte = (wr_strobe && in_reload) ? (4'h1 << addr[1:0]) : 4'h0;

  // Config writes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg0_r <= timer_pkg::RST_BYTE[3:0];
      cfg1_r <= timer_pkg::RST_BYTE[3:0];
      clk_r <= timer_pkg::RST_BYTE;
      run_r <= timer_pkg::RST_BYTE;
      mask_r <= timer_pkg::RST_BYTE[timer_pkg::NUM_EVENTS-1:0];
    end else begin
      if (wr_mode) {cfg1_r, cfg0_r} <= wdata;
      if (wr_clock) clk_r <= wdata;
      if (wr_run) run_r <= wdata;
      if (wr_mask) mask_r <= wdata[timer_pkg::NUM_EVENTS-1:0];
    end
  end

  // ***********************************************
  // Count input synchronisers
  // ***********************************************
  logic [1:0] pin_meta_r;
  logic [1:0] pin_sync_r;
  logic [1:0] pin_prev_r;
  logic [1:0] fall;
  wire [1:0] pins = {count_input_one, count_input_zero};

  // Two stages then one history bit; an edge costs three cycles of latency
  // but needs each level held only two cycles, which keeps sysclk/4 safe
  generate
    for (genvar i = 0; i < 2; i++) begin : g_sync
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          pin_meta_r[i] <= 1'b0;
          pin_sync_r[i] <= 1'b0;
          pin_prev_r[i] <= 1'b0;
        end else begin
          pin_meta_r[i] <= pins[i];
          pin_sync_r[i] <= pin_meta_r[i];
          pin_prev_r[i] <= pin_sync_r[i];
        end
      end
      assign fall[i] = pin_prev_r[i] && !pin_sync_r[i];
    end
  endgenerate

  // ***********************************************
  // Prescalers
  // ***********************************************
  logic [5:0] div48_r;
  logic [5:0] div12_r;
  logic [2:0] ext_cnt_r;
  logic ext_meta_r;
  logic ext_sync_r;
  logic ext_prev_r;
  wire ext_rise = ext_sync_r && !ext_prev_r;
  wire div4_tick = div48_r[1:0] == timer_pkg::DIV4_LAST[1:0];
  wire div48_tick = div48_r == timer_pkg::DIV48_LAST;
  wire div12_tick = div12_r == timer_pkg::DIV12_LAST;
  wire ext8_tick = ext_rise && ext_cnt_r == timer_pkg::EXT8_LAST;

  // Free-running dividers; /4 rides on the low bits of the /48 count
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div48_r <= 6'h00;
      div12_r <= 6'h00;
      ext_cnt_r <= 3'h0;
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      div48_r <= div48_tick ? 6'h00 : div48_r + 6'h01;
      div12_r <= div12_tick ? 6'h00 : div12_r + 6'h01;
      ext_meta_r <= ext_osc_clk;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
      if (ext_rise) ext_cnt_r <= ext_cnt_r + 3'h1;
    end
  end

  // Prescaled tick shared by timers 0 and 1
  wire pre_tick =
    (clk_r.prescale_select == timer_pkg::PRE_DIV12) ? div12_tick :
    (clk_r.prescale_select == timer_pkg::PRE_DIV4) ? div4_tick :
    (clk_r.prescale_select == timer_pkg::PRE_DIV48) ? div48_tick : ext8_tick;

  // ***********************************************
  // Timer ticks
  // ***********************************************
  wire run0_ok = run_r[timer_pkg::POS_RUN_T0] && (!cfg0_r.gate || external_gate_input_zero);
  wire run1_ok = run_r[timer_pkg::POS_RUN_T1] && (!cfg1_r.gate || external_gate_input_one);
  wire time0 = clk_r.timer0_sysclk_select ? 1'b1 : pre_tick;
  wire time1 = clk_r.timer1_sysclk_select ? 1'b1 : pre_tick;
  wire tick0 = run0_ok && (cfg0_r.counter ? fall[0] : time0);
  wire tick1 = run1_ok && (cfg1_r.counter ? fall[1] : time1);
  // Split high byte of timer 0 runs on timer 1's run bit, time base only
  wire tick0_hi = run_r[timer_pkg::POS_RUN_T1] && time0;
  wire slow2 = clk_r.t2_ext ? ext8_tick : div12_tick;
  wire slow3 = clk_r.t3_ext ? ext8_tick : div12_tick;
  wire tick2 = run_r[timer_pkg::POS_RUN_T2] && (clk_r.t2_sys || slow2);
  wire tick3 = run_r[timer_pkg::POS_RUN_T3] && (clk_r.t3_sys || slow3);

  // ***********************************************
  // The four timers
  // ***********************************************
  logic [15:0] cnt0;
  logic [15:0] cnt1;
  logic [15:0] cnt2;
  logic [15:0] cnt3;
  logic [15:0] rl2;
  logic [15:0] rl3;
  logic ovf0_lo;
  logic ovf0_hi;
  logic ovf1_lo;
  logic ovf2_lo;
  logic ovf2_hi;
  logic ovf3_lo;
  logic ovf3_hi;

  // Four independent instances
  classic_timer #(.SPLIT_OK(1'b1)) u_t0 (
    .mclk(mclk), .rstn(rstn), .tick_lo(tick0), .tick_hi(tick0_hi),
    .mode(cfg0_r.mode), .wr_lo(wr_cnt_byte[0]), .wr_hi(wr_cnt_byte[1]),
    .wdata(wdata), .count(cnt0), .ovf_lo(ovf0_lo), .ovf_hi(ovf0_hi)
  );
  classic_timer #(.SPLIT_OK(1'b0)) u_t1 (
    .mclk(mclk), .rstn(rstn), .tick_lo(tick1), .tick_hi(1'b0),
    .mode(cfg1_r.mode), .wr_lo(wr_cnt_byte[2]), .wr_hi(wr_cnt_byte[3]),
    .wdata(wdata), .count(cnt1), .ovf_lo(ovf1_lo), .ovf_hi()
  );
  reload_timer u_t2 (
    .mclk(mclk), .rstn(rstn), .tick(tick2), .split(run_r[timer_pkg::POS_SPLIT_T2]),
    .wr_cnt_lo(wr_cnt_byte[4]), .wr_cnt_hi(wr_cnt_byte[5]),
    .wr_rl_lo(wr_rl_byte[0]), .wr_rl_hi(wr_rl_byte[1]), .wdata(wdata),
    .count(cnt2), .reload(rl2), .ovf_lo(ovf2_lo), .ovf_hi(ovf2_hi)
  );
  reload_timer u_t3 (
    .mclk(mclk), .rstn(rstn), .tick(tick3), .split(run_r[timer_pkg::POS_SPLIT_T3]),
    .wr_cnt_lo(wr_cnt_byte[6]), .wr_cnt_hi(wr_cnt_byte[7]),
    .wr_rl_lo(wr_rl_byte[2]), .wr_rl_hi(wr_rl_byte[3]), .wdata(wdata),
    .count(cnt3), .reload(rl3), .ovf_lo(ovf3_lo), .ovf_hi(ovf3_hi)
  );

  // ***********************************************
  // Interrupt status
  // ***********************************************
  // Event order follows the status bit positions
  assign events = {ovf3_hi, ovf3_lo, ovf2_hi, ovf2_lo, ovf1_lo || ovf0_hi, ovf0_lo};
  // Set beats a same-cycle write-one clear
  assign status_nxt = events | (status_r & ~(wr_status ? wdata[timer_pkg::NUM_EVENTS-1:0] :
    {timer_pkg::NUM_EVENTS{1'b0}}));
  assign irq = |(status_r & mask_r);

  // Sticky flags
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) status_r <= timer_pkg::RST_BYTE[timer_pkg::NUM_EVENTS-1:0];
    else status_r <= status_nxt;
  end

  // ***********************************************
  // Read path
  // ***********************************************
  wire [63:0] cnt_all = {cnt3, cnt2, cnt1, cnt0};
  wire [31:0] rl_all = {rl3, rl2};
  wire [7:0] cnt_sel = cnt_all[{addr[2:0], 3'h0} +: 8];
  wire [7:0] rl_sel = rl_all[{addr[1:0], 3'h0} +: 8];
  // Unmapped offsets read as zero
  always_comb begin
    if (addr == timer_pkg::OFS_MODE) rdata_nxt = {cfg1_r, cfg0_r};
    else if (addr == timer_pkg::OFS_CLOCK) rdata_nxt = clk_r;
    else if (addr == timer_pkg::OFS_RUN) rdata_nxt = {2'h0, run_r[5:0]};
    else if (addr == timer_pkg::OFS_STATUS) rdata_nxt = {2'h0, status_r};
    else if (addr == timer_pkg::OFS_MASK) rdata_nxt = {2'h0, mask_r};
    else if (in_count) rdata_nxt = cnt_sel;
    else if (in_reload) rdata_nxt = rl_sel;
    else rdata_nxt = 8'h00;
  end

  // Data valid only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) rdata_r <= 8'h00;
    else rdata_r <= rd_strobe ? rdata_nxt : 8'h00;
  end
  assign rdata = rdata_r;

  // ***********************************************
  // Checks
  // ***********************************************
  wire quiet0 = !(wr_cnt_byte[0] || wr_cnt_byte[1]);
  wire quiet1 = !(wr_cnt_byte[2] || wr_cnt_byte[3]);

  a_wrap_13bit: assert property (@(posedge mclk) disable iff (!rstn)
    cfg0_r.mode == timer_pkg::MODE_13BIT && tick0 && quiet0 && cnt0[15:8] == 8'hff &&
    cnt0[4:0] == 5'h1f |=> cnt0[15:8] == 8'h00 && cnt0[4:0] == 5'h00 && status_r[0])
    else $error("13-bit wrap did not clear count and set flag");

  a_irq_follows: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(status_r[0]) && mask_r[0] |-> irq)
    else $error("unmasked flag gave no interrupt");

  a_edge_count: assert property (@(posedge mclk) disable iff (!rstn)
    cfg0_r.mode == timer_pkg::MODE_16BIT && cfg0_r.counter && run0_ok && fall[0] && quiet0
    |=> cnt0 == $past(cnt0) + 16'h0001)
    else $error("falling edge not counted");

  a_gate_hold: assert property (@(posedge mclk) disable iff (!rstn)
    cfg0_r.gate && !external_gate_input_zero && quiet0 && cfg0_r.mode != timer_pkg::MODE_SPLIT
    |=> $stable(cnt0))
    else $error("gated timer moved");

  a_sysclk_step: assert property (@(posedge mclk) disable iff (!rstn)
    cfg1_r.mode == timer_pkg::MODE_16BIT && !cfg1_r.counter && clk_r.timer1_sysclk_select &&
    run1_ok && quiet1 [*2] |=> cnt1 == $past(cnt1, 2) + 16'h0002)
    else $error("sysclk select did not step every cycle");

  a_div4_period: assert property (@(posedge mclk) disable iff (!rstn)
    div4_tick |=> !div4_tick [*3] ##1 div4_tick)
    else $error("divide by 4 period wrong");

  a_div48_period: assert property (@(posedge mclk) disable iff (!rstn)
    div48_tick |-> ##48 div48_tick)
    else $error("divide by 48 period wrong");

  a_div12_period: assert property (@(posedge mclk) disable iff (!rstn)
    div12_tick |=> !div12_tick [*8] ##4 div12_tick)
    else $error("divide by 12 period wrong");

  a_no_split_t1: assert property (@(posedge mclk) disable iff (!rstn)
    cfg1_r.mode == timer_pkg::MODE_SPLIT && quiet1 |=> $stable(cnt1))
    else $error("timer 1 ran in split mode");

  a_reload_16: assert property (@(posedge mclk) disable iff (!rstn)
    tick2 && !run_r[timer_pkg::POS_SPLIT_T2] && cnt2 == 16'hffff &&
    !(wr_cnt_byte[4] || wr_cnt_byte[5]) |=> cnt2 == $past(rl2) && status_r[3])
    else $error("16-bit reload missed");

  a_fall_pulse: assert property (@(posedge mclk) disable iff (!rstn)
    fall[0] |=> !fall[0])
    else $error("edge pulse longer than one cycle");

  a_reload_8: assert property (@(posedge mclk) disable iff (!rstn)
    cfg0_r.mode == timer_pkg::MODE_8RELOAD && tick0 && quiet0 && cnt0[7:0] == 8'hff
    |=> cnt0[7:0] == cnt0[15:8])
    else $error("8-bit reload missed");

  c_split_t0: cover property (@(posedge mclk) disable iff (!rstn)
    cfg0_r.mode == timer_pkg::MODE_SPLIT && ovf0_hi);
  c_counter_wrap: cover property (@(posedge mclk) disable iff (!rstn)
    cfg0_r.counter && ovf0_lo);
  c_t3_split: cover property (@(posedge mclk) disable iff (!rstn)
    ovf3_lo ##[1:600] ovf3_hi);

endmodule : four_counter_timer_unit

// *** testbench/event_source.sv ***
// Purpose: Far-side model of the event pins and the external oscillator
// Assumes: Count pins idle high; 100 MHz system clock
// Notes: Pulses come at the fastest rate the unit must count
module event_source (
  input wire logic mclk,
  output logic count_input_zero,
  output logic count_input_one,
  output logic ext_osc_clk
);
  timeunit 1ns;
  timeprecision 1ps;

  // ***********************************************
  // Pin drivers
  // ***********************************************
  // Idle levels at time zero, so no false edge after reset
  initial begin
    count_input_zero = 1'b1;
    count_input_one = 1'b1;
    ext_osc_clk = 1'b0;
  end

  // Free-running oscillator at mclk/8, below the mclk/4 limit of its sync path
  always #40 ext_osc_clk = ~ext_osc_clk;

  // Each level held two full cycles: period of four cycles, a quarter of mclk
  task automatic send_falls(input int n);
    for (int i = 0; i < n; i++) begin
      count_input_zero <= 1'b0;
      count_input_one <= 1'b0;
      repeat (2) @(posedge mclk);
      count_input_zero <= 1'b1;
      count_input_one <= 1'b1;
      repeat (2) @(posedge mclk);
    end
  endtask : send_falls
endmodule : event_source

// *** testbench/tb_four_counter_timer_unit.sv ***
// Purpose: Self-checking bench of the four counter/timer unit
// Assumes: Register port with one-cycle strobes, read data one cycle later
// Notes: Free-running dividers make some counts uncertain by one tick
module tb_four_counter_timer_unit;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] R_MD = timer_pkg::OFS_MODE;
  localparam logic [7:0] R_CK = timer_pkg::OFS_CLOCK;
  localparam logic [7:0] R_RN = timer_pkg::OFS_RUN;
  localparam logic [7:0] R_ST = timer_pkg::OFS_STATUS;
  localparam logic [7:0] R_MK = timer_pkg::OFS_MASK;
  localparam logic [7:0] R_CT = timer_pkg::OFS_COUNT;
  localparam logic [7:0] R_RL = timer_pkg::OFS_RELOAD;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_strobe = 1'b0;
  logic rd_strobe = 1'b0;
  logic gate_enable_zero = 1'b0;
  logic gate1 = 1'b0;
  logic [7:0] rdata;
  logic cin0, cin1, osc, irq;
  logic [7:0] v;
  int n_mismatch = 0;
  int num_checks = 0;

  // ***********************************************
  // Clock, design and far side
  // ***********************************************
  always #5 mclk = ~mclk;

  four_counter_timer_unit dut (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata), .count_input_zero(cin0),
    .count_input_one(cin1), .external_gate_input_zero(gate_enable_zero),
    .external_gate_input_one(gate1), .ext_osc_clk(osc), .irq(irq));
  event_source src (.mclk(mclk), .count_input_zero(cin0), .count_input_one(cin1),
    .ext_osc_clk(osc));

  // ***********************************************
  // Bus and compare tasks
  // ***********************************************
  // Each access starts at a fresh edge, so a strobe is never set twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_strobe <= 1'b1;
    @(posedge mclk);
    wr_strobe <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge mclk);
    rd_strobe <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic check_eq(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_eq

  // Range form for counts whose divider phase is free
  task automatic check_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    num_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : check_rng

  task automatic rd_eq(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check_eq(d, exp);
  endtask : rd_eq

  // ***********************************************
  // Scenarios
  // ***********************************************
  // Reset values, unused run bits read zero, unmapped place
  task automatic t_reset();
    logic [7:0] ofs [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0f, 8'h10, 8'h13, 8'h20};
    foreach (ofs[i]) rd_eq(ofs[i], 8'h00);
    wr(R_RN, 8'hc0);
    wr(8'h20, 8'h5a);
    rd_eq(R_RN, 8'h00);
    rd_eq(8'h20, 8'h00);
    $display("reset test done");
  endtask : t_reset

  // Both timers count pin falls; sysclk select set but ignored
  task automatic t_count();
    wr(R_MD, 8'h55);
    wr(R_CK, 8'h0c);
    wr(R_RN, 8'h03);
    src.send_falls(20);
    repeat (6) @(posedge mclk);
    wr(R_RN, 8'h00);
    rd_eq(R_CT, 8'h14);
    rd_eq(R_CT | 8'h02, 8'h14);
    rd_eq(R_CT | 8'h01, 8'h00);
    $display("count test done");
  endtask : t_count

  // 13-bit wrap, flag, mask and W1C clear
  task automatic t_wrap();
    wr(R_CT, 8'h1f);
    wr(R_CT | 8'h01, 8'hff);
    wr(R_MD, 8'h00);
    wr(R_CK, 8'h04);
    wr(R_MK, 8'h01);
    wr(R_RN, 8'h01);
    wr(R_RN, 8'h00);
    rd_eq(R_CT | 8'h01, 8'h00);
    rd_eq(R_ST, 8'h01);
    check_eq({7'h00, irq}, 8'h01);
    wr(R_MK, 8'h00);
    // Let the mask update settle before looking at the level
    #1;
    check_eq({7'h00, irq}, 8'h00);
    wr(R_MK, 8'h01);
    wr(R_ST, 8'h01);
    rd_eq(R_ST, 8'h00);
    check_eq({7'h00, irq}, 8'h00);
    $display("wrap test done");
  endtask : t_wrap

  // Gate closed holds the count, open lets sysclk ticks through
  task automatic t_gate();
    wr(R_CT, 8'h00);
    wr(R_MD, 8'h09);
    wr(R_RN, 8'h01);
    repeat (20) @(posedge mclk);
    rd_eq(R_CT, 8'h00);
    @(posedge mclk);
    gate_enable_zero <= 1'b1;
    repeat (10) @(posedge mclk);
    gate_enable_zero <= 1'b0;
    rd(R_CT, v);
    check_rng(v, 8'h08, 8'h0c);
    wr(R_RN, 8'h00);
    $display("gate test done");
  endtask : t_gate

  // Every prescale code on timer 1 over one fixed window
  task automatic t_prescale();
    int dv [4] = '{12, 4, 48, 64};
    int e;
    wr(R_MD, 8'h10);
    for (int p = 0; p < 4; p++) begin
      e = 480 / dv[p];
      wr(R_CT | 8'h02, 8'h00);
      wr(R_CK, 8'(p));
      wr(R_RN, 8'h02);
      repeat (480) @(posedge mclk);
      wr(R_RN, 8'h00);
      rd(R_CT | 8'h02, v);
      check_rng(v, 8'(e - 1), 8'(e + 1));
    end
    // Sysclk select: exactly one step per cycle of run
    wr(R_CT | 8'h02, 8'h00);
    wr(R_CK, 8'h08);
    wr(R_RN, 8'h02);
    wr(R_RN, 8'h00);
    rd_eq(R_CT | 8'h02, 8'h02);
    $display("prescale test done");
  endtask : t_prescale

  // Split timer 0 uses both bytes; timer 1 in the same code holds
  task automatic t_split();
    wr(R_CT, 8'h00);
    wr(R_CT | 8'h01, 8'h00);
    wr(R_CT | 8'h02, 8'h5a);
    wr(R_MD, 8'h33);
    wr(R_CK, 8'h0c);
    wr(R_RN, 8'h03);
    repeat (20) @(posedge mclk);
    wr(R_RN, 8'h00);
    rd(R_CT, v);
    check_rng(v, 8'h12, 8'h18);
    rd(R_CT | 8'h01, v);
    check_rng(v, 8'h12, 8'h18);
    rd_eq(R_CT | 8'h02, 8'h5a);
    $display("split test done");
  endtask : t_split

  // 8-bit reload on timer 0: count stays within reload..ff
  task automatic t_reload8();
    wr(R_ST, 8'h3f);
    wr(R_CT, 8'hfe);
    wr(R_CT | 8'h01, 8'hfd);
    wr(R_MD, 8'h02);
    wr(R_CK, 8'h04);
    wr(R_RN, 8'h01);
    repeat (10) @(posedge mclk);
    wr(R_RN, 8'h00);
    rd(R_CT, v);
    check_rng(v, 8'hfd, 8'hff);
    rd_eq(R_CT | 8'h01, 8'hfd);
    rd_eq(R_ST, 8'h01);
    $display("reload8 test done");
  endtask : t_reload8

  // Timers 2 and 3: 16-bit reload, split halves, divided clock
  task automatic t_auto();
    wr(R_RL, 8'hf0);
    wr(R_RL | 8'h01, 8'hff);
    wr(R_CT | 8'h04, 8'hf0);
    wr(R_CT | 8'h05, 8'hff);
    wr(R_CK, 8'h10);
    wr(R_ST, 8'h3f);
    wr(R_RN, 8'h04);
    repeat (20) @(posedge mclk);
    wr(R_RN, 8'h00);
    rd_eq(R_ST, 8'h08);
    rd_eq(R_CT | 8'h05, 8'hff);
    wr(R_RL, 8'hfe);
    wr(R_RL | 8'h01, 8'hfc);
    wr(R_ST, 8'h3f);
    wr(R_RN, 8'h14);
    repeat (8) @(posedge mclk);
    wr(R_RN, 8'h00);
    rd_eq(R_ST, 8'h0c);
    wr(R_RL | 8'h02, 8'hfc);
    wr(R_RL | 8'h03, 8'hff);
    wr(R_CT | 8'h06, 8'hfc);
    wr(R_CT | 8'h07, 8'hff);
    wr(R_ST, 8'h3f);
    wr(R_RN, 8'h08);
    repeat (16) @(posedge mclk);
    rd_eq(R_ST, 8'h00);
    repeat (50) @(posedge mclk);
    wr(R_RN, 8'h00);
    rd_eq(R_ST, 8'h20);
    // Timer 3 on ext/8: three ticks need at least 129 cycles
    wr(R_CK, 8'h80);
    wr(R_CT | 8'h06, 8'hfd);
    wr(R_CT | 8'h07, 8'hff);
    wr(R_ST, 8'h3f);
    wr(R_RN, 8'h08);
    repeat (100) @(posedge mclk);
    rd_eq(R_ST, 8'h00);
    repeat (120) @(posedge mclk);
    wr(R_RN, 8'h00);
    rd_eq(R_ST, 8'h20);
    $display("auto-reload test done");
  endtask : t_auto

  // ***********************************************
  // Sequence, watchdog and verdict
  // ***********************************************
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_count();
    t_wrap();
    t_gate();
    t_prescale();
    t_split();
    t_reload8();
    t_auto();
    give_verdict();
  end

  // Run needs about 2600 cycles; far more means a hang
  initial begin
    #200us;
    n_mismatch++;
    give_verdict();
  end
endmodule : tb_four_counter_timer_unit
